// ===== rtl/ife_defs.svh
// Address map, bit positions and reset values of the interrupt flag and enable unit.
`ifndef IFE_DEFS_SVH
`define IFE_DEFS_SVH

`define IFE_ADDR_FLAG_ALIAS 8'h10
`define IFE_ADDR_FLAGS      8'h11
`define IFE_ADDR_ENABLES    8'h12
`define IFE_ADDR_CTRA_LOW   8'h18
`define IFE_ADDR_CTRA_LATCH 8'h1A
`define IFE_ADDR_CTRB_LOW   8'h1C
`define IFE_ADDR_CTRB_LATCH 8'h1E

`define IFE_ALIAS_READ      8'hFF
`define IFE_UNMAPPED_READ   8'h00
`define IFE_FLAGS_RESET     8'h00
`define IFE_ENABLES_RESET   8'h00

`define IFE_BIT_CTRA        4
`define IFE_BIT_CTRB        5
`define IFE_BIT_RX          6
`define IFE_BIT_TX          7
`define IFE_NUM_EDGE        4
`define IFE_FALL_MASK       4'hC
`define IFE_RX_STATUS_MASK  8'h0F
`define IFE_TX_EMPTY_BIT    6
`define IFE_TX_HOLD_BIT     5
`define IFE_TX_DONE_BIT     7

`endif

// ===== rtl/ife_edge_detect.sv
// Single-line edge detector with selectable polarity.
`timescale 1ns/100ps
module ife_edge_detect #(
  parameter bit FALLING = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clkEn,
  input  wire logic lineIn,
  output logic      edgeSeen
);

  logic prev_r;
  logic prev_nxt;
  logic primed_r;
  logic primed_nxt;

  // ----------------------------------------------------------------
  // Sample and compare.
  // ----------------------------------------------------------------
  always_comb
  begin
    prev_nxt   = lineIn;
    primed_nxt = 1'b1;
    if (FALLING)
      edgeSeen = clkEn & primed_r & prev_r & ~lineIn;
    else
      edgeSeen = clkEn & primed_r & ~prev_r & lineIn;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prev_r   <= 1'b0;
      primed_r <= 1'b0;
    end
    else if (clkEn)
    begin
      prev_r   <= prev_nxt;  // [R16]
      primed_r <= primed_nxt;
    end
  end

endmodule

// ===== rtl/ife_irq_unit.sv
// Interrupt flag and enable registers with the maskable request output.
//
// Functional notes
// R1: Eight sources each have an enable bit, and a set flag with its enable one raises the request.
// R2: With several conditions pending the request stays high until every enabled one is cleared.
// R3: The eight-bit pending flag register reads back at any time at location 11.
// R4: A read at 10 returns FF and a write to 10 lands in the flag register, clearing chosen bits.
// R5: A one written to an edge flag has no effect, so a flag set after the read survives.
// R6: The source mask register at 12 sets bits written one and clears bits written zero.
// R7: Reset clears every bit of the source mask register.
// R8: Flags 0 and 1 set on a rising edge of port A lines 0 and 1.
// R9: Flags 2 and 3 set on a falling edge of port A lines 2 and 3.
// R10: Edge flags clear only by a bit clear aimed at location 10 or by reset; the code also clears them on a bit clear written to 11.
// R11: Flag 4 sets on counter A underflow and clears on a read of 18, any write to 1A, or reset.
// R12: Flag 5 sets on counter B underflow and clears on a read of 1C, any write to 1E, or reset.
// R13: Flag 6 is set while any serial status bit 0 to 3 is one and clears when all are zero.
// R14: Flag 7 is set while status 6 is one with 5 zero, or status 7 is one, and clears otherwise.
// R15: The processor ignores the request while its interrupt-disable bit is one.
// R16: Edge detectors sample port A lines 0 to 3 every clock and compare with the last sample.
// R17: The request is the OR of all flag and enable pairs, held as a level.
`timescale 1ns/100ps
`include "ife_defs.svh"
module ife_irq_unit (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            clkEn,
  input  wire logic [7:0]      busAddr,
  input  wire logic            busRd,
  input  wire logic            busWr,
  input  wire logic [7:0]      busWdata,
  output ife_pkg::ife_byte_t   busRdata_r,
  input  wire logic [3:0]      portA,
  input  wire logic            ctrAUnderflow,
  input  wire logic            ctrBUnderflow,
  input  wire logic [7:0]      serialStatus,
  output ife_pkg::ife_byte_t   pendingFlags_r,
  output ife_pkg::ife_byte_t   sourceMask_r,
  output logic                 irqReq_r
);

  localparam logic [3:0] FALL_SEL = `IFE_FALL_MASK;

  ife_pkg::ife_edge_t edgeSeen;
  ife_pkg::ife_byte_t flags_nxt;
  ife_pkg::ife_byte_t mask_nxt;
  ife_pkg::ife_byte_t rdata_nxt;
  logic               irq_nxt;
  logic               flagWrite;
  logic               maskWrite;
  logic               clrCtrA;
  logic               clrCtrB;
  logic               rxCond;
  logic               txCond;

  // ----------------------------------------------------------------
  // Edge detectors on port A lines 0 to 3.
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `IFE_NUM_EDGE; gi++)
    begin : gEdge
      ife_edge_detect #(
        .FALLING (FALL_SEL[gi])  // [R8] [R9]
      ) uEdge (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .clkEn    (clkEn),
        .lineIn   (portA[gi]),
        .edgeSeen (edgeSeen[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Address decode and serial status conditions.
  // ----------------------------------------------------------------
  always_comb
  begin
    flagWrite = busWr & ((busAddr == `IFE_ADDR_FLAG_ALIAS) | (busAddr == `IFE_ADDR_FLAGS));  // [R4]
    maskWrite = busWr & (busAddr == `IFE_ADDR_ENABLES);
    clrCtrA   = (busRd & (busAddr == `IFE_ADDR_CTRA_LOW))
              | (busWr & (busAddr == `IFE_ADDR_CTRA_LATCH));  // [R11]
    clrCtrB   = (busRd & (busAddr == `IFE_ADDR_CTRB_LOW))
              | (busWr & (busAddr == `IFE_ADDR_CTRB_LATCH));  // [R12]
    rxCond    = |(serialStatus & `IFE_RX_STATUS_MASK);  // [R13]
    txCond    = (serialStatus[`IFE_TX_EMPTY_BIT] & ~serialStatus[`IFE_TX_HOLD_BIT])
              | serialStatus[`IFE_TX_DONE_BIT];  // [R14]
  end

  // ----------------------------------------------------------------
  // Flag, mask, read data and request next values.
  // ----------------------------------------------------------------
  always_comb
  begin
    flags_nxt = pendingFlags_r;
    for (int i = 0; i < `IFE_NUM_EDGE; i++)
    begin
      if (flagWrite && !busWdata[i])
        flags_nxt[i] = 1'b0;  // [R10] [R5]
      if (edgeSeen[i])
        flags_nxt[i] = 1'b1;  // [R8] [R9]
    end
    if (clrCtrA)
      flags_nxt[`IFE_BIT_CTRA] = 1'b0;  // [R11]
    if (ctrAUnderflow)
      flags_nxt[`IFE_BIT_CTRA] = 1'b1;  // [R11]
    if (clrCtrB)
      flags_nxt[`IFE_BIT_CTRB] = 1'b0;  // [R12]
    if (ctrBUnderflow)
      flags_nxt[`IFE_BIT_CTRB] = 1'b1;  // [R12]
    flags_nxt[`IFE_BIT_RX] = rxCond;  // [R13]
    flags_nxt[`IFE_BIT_TX] = txCond;  // [R14]

    mask_nxt = sourceMask_r;
    if (maskWrite)
      mask_nxt = busWdata;  // [R6]

    rdata_nxt = busRdata_r;
    if (busRd)
    begin
      unique case (busAddr)
        `IFE_ADDR_FLAG_ALIAS: rdata_nxt = `IFE_ALIAS_READ;  // [R4]
        `IFE_ADDR_FLAGS:      rdata_nxt = pendingFlags_r;  // [R3]
        `IFE_ADDR_ENABLES:    rdata_nxt = sourceMask_r;
        default:              rdata_nxt = `IFE_UNMAPPED_READ;
      endcase
    end

    irq_nxt = |(flags_nxt & mask_nxt);  // [R1] [R2] [R17]
  end

  // ----------------------------------------------------------------
  // State registers.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pendingFlags_r <= `IFE_FLAGS_RESET;
      sourceMask_r   <= `IFE_ENABLES_RESET;  // [R7]
      busRdata_r     <= `IFE_UNMAPPED_READ;
      irqReq_r       <= 1'b0;
    end
    else if (clkEn)
    begin
      pendingFlags_r <= flags_nxt;
      sourceMask_r   <= mask_nxt;
      busRdata_r     <= rdata_nxt;
      irqReq_r       <= irq_nxt;  // [R17]
    end
  end

endmodule

// ===== rtl/ife_pkg.sv
// Types shared by the interrupt flag and enable unit.
package ife_pkg;
  typedef logic [7:0] ife_byte_t;
  typedef logic [3:0] ife_edge_t;
endpackage

// ===== verif/ife_cpu_model.sv
// Processor side: takes the request only while interrupts are allowed.
`timescale 1ns/100ps
module ife_cpu_model (
  input wire logic irqReq_r, iDisable,
  output logic takeIrq
);
  assign takeIrq = irqReq_r & ~iDisable;
endmodule

// ===== verif/ife_irq_unit_monitor.sv
// Port checker of the interrupt flag and enable unit.
`timescale 1ns/100ps
module ife_irq_unit_monitor (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               clkEn,
  input wire logic               busRd,
  input wire logic               busWr,
  input wire logic [7:0]         busAddr,
  input wire logic [7:0]         busWdata,
  input wire logic [3:0]         portA,
  input wire logic               ctrAUnderflow,
  input wire logic               ctrBUnderflow,
  input wire logic [7:0]         serialStatus,
  input wire ife_pkg::ife_byte_t busRdata_r,
  input wire ife_pkg::ife_byte_t pendingFlags_r,
  input wire ife_pkg::ife_byte_t sourceMask_r,
  input wire logic               irqReq_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_irq_level: assert property (irqReq_r ==
    |(pendingFlags_r & sourceMask_r)) else $error("irq level");
  a_mask_write: assert property (clkEn && busWr && busAddr == 8'h12 |=>
    sourceMask_r == $past(busWdata)) else $error("mask write");
  a_flag_read: assert property (clkEn && busRd && busAddr == 8'h11 |=>
    busRdata_r == $past(pendingFlags_r)) else $error("flag read");
  a_alias_read: assert property (clkEn && busRd && busAddr == 8'h10 |=>
    busRdata_r == 8'hFF) else $error("alias read");
  a_rise_set: assert property (clkEn && $past(clkEn) && !$past(rst) && $rose(portA[0])
    |=> pendingFlags_r[0]) else $error("rise flag");
  a_fall_set: assert property (clkEn && $past(clkEn) && !$past(rst) && $fell(portA[3])
    |=> pendingFlags_r[3]) else $error("fall flag");
  a_edge_keep: assert property (pendingFlags_r[0] && !(busWr && busAddr[7:1] == 7'h08)
    |=> pendingFlags_r[0]) else $error("edge flag lost");
  a_rx_follow: assert property (!$past(rst) && $past(clkEn) |->
    pendingFlags_r[6] == |($past(serialStatus) & 8'h0F)) else $error("rx flag");
  a_tx_follow: assert property (!$past(rst) && $past(clkEn) |->
    pendingFlags_r[7] == (($past(serialStatus[6]) && !$past(serialStatus[5]))
    || $past(serialStatus[7]))) else $error("tx flag");
  a_ctr_set: assert property (clkEn && ctrAUnderflow |=>
    pendingFlags_r[4]) else $error("counter flag not set");
  a_ctr_clear: assert property (clkEn && busRd && busAddr == 8'h18 && !ctrAUnderflow |=>
    !pendingFlags_r[4]) else $error("counter flag not cleared");
  a_mask_reset: assert property ($fell(rst) |->
    sourceMask_r == 8'h00 && !irqReq_r) else $error("mask after reset");
endmodule
bind ife_irq_unit ife_irq_unit_monitor i_ife_mon (.*);

// ===== verif/ife_irq_unit_tb_top.sv
// Bench of the interrupt flag and enable unit.
`timescale 1ns/100ps
module ife_irq_unit_tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, busRd = 1'b0, busWr = 1'b0, rdPend = 1'b0;
  logic ctrAUnderflow = 1'b0, ctrBUnderflow = 1'b0, irqReq_r, takeIrq;
  logic clkEn = 1'b1, iDisable = 1'b0;
  logic [7:0] busAddr = 8'h00, busWdata = 8'h00, serialStatus = 8'h00, expQ[$];
  logic [3:0] portA = 4'hC;
  logic [31:0] lfsr = 32'h706D;
  ife_pkg::ife_byte_t busRdata_r, pendingFlags_r, sourceMask_r;
  int n_fail = 0, samples_checked = 0;
  always #4 clk_sys = ~clk_sys;
  ife_irq_unit i_ife_irq_unit (.*);
  ife_cpu_model i_ife_cpu_model (.*);
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], ^(v & 32'h80200003)};
  endfunction
  task automatic cyc(input logic r, w, input logic [7:0] a, d);
    @(posedge clk_sys);
    {busRd, busWr, busAddr, busWdata} <= {r, w, a, d};
  endtask
  task automatic rd(input logic [7:0] a, e);
    cyc(1'b1, 1'b0, a, 8'h00);
    expQ.push_back(e);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge clk_sys);
    samples_checked++;
    if ({irqReq_r, takeIrq} !== {e, e & ~iDisable})
    begin
      n_fail++;
      $display("unexpected at %0t: irq %b take %b", $time, irqReq_r, takeIrq);
    end
  endtask
  task automatic finish_test;
    n_fail += expQ.size();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge clk_sys)
  begin
    samples_checked += rdPend;
    if (rdPend && busRdata_r !== expQ.pop_front())
    begin
      n_fail++;
      $display("unexpected at %0t: read %h", $time, busRdata_r);
    end
    rdPend = busRd;
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h12, 8'h00);
    rd(8'h10, 8'hFF);
    repeat (4)
    begin
      lfsr = nxt(lfsr);
      serialStatus <= lfsr[15:8];
      cyc(1'b0, 1'b1, 8'h12, lfsr[7:0]);
      rd(8'h12, lfsr[7:0]);
    end
    serialStatus <= 8'h00;
    cyc(1'b0, 1'b1, 8'h12, 8'hFF);
    portA <= 4'h3;
    rd(8'h11, 8'h0F);
    chk_irq(1'b1);
    cyc(1'b0, 1'b1, 8'h10, 8'hFE);
    cyc(1'b0, 1'b1, 8'h11, 8'hFF);
    chk_irq(1'b1);
    rd(8'h11, 8'h0E);
    for (int k = 0; k < 4; k++)
    begin
      {ctrBUnderflow, ctrAUnderflow} <= k[0] ? 2'b10 : 2'b01;
      cyc(1'b0, 1'b0, 8'h00, 8'h00);
      {ctrBUnderflow, ctrAUnderflow} <= 2'b00;
      rd(8'h11, 8'h0E | (8'h10 << k[0]));
      cyc(!k[1], k[1], 8'h18 | {5'h00, k[0], k[1], 1'b0}, 8'h00);
      if (!k[1])
        expQ.push_back(8'h00);
      rd(8'h11, 8'h0E);
    end
    iDisable <= 1'b1;
    cyc(1'b0, 1'b1, 8'h12, 8'h00);
    clkEn <= 1'b0;
    chk_irq(1'b1);
    iDisable <= 1'b0;
    rd(8'h12, 8'hFF);
    clkEn <= 1'b1;
    chk_irq(1'b1);
    cyc(1'b0, 1'b1, 8'h12, 8'h01);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
    chk_irq(1'b0);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h12, 8'h00);
    rd(8'h11, 8'h00);
    chk_irq(1'b0);
    repeat (3) cyc(1'b0, 1'b0, 8'h00, 8'h00);
    finish_test;
  end
endmodule
